// >>> core/acr_consts.svh
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// Clock figures in MHz
`define ACR_REF_MHZ 50
`define ACR_SYS_MHZ 100
`define ACR_SPI_MHZ 2
// Half period of the serial clock in system cycles
`define ACR_SCLK_HALF ((`ACR_SYS_MHZ / `ACR_SPI_MHZ) / 2)
`define ACR_DIV_W 5
// Frame shape
`define ACR_FRAME_BITS 16
`define ACR_BIT_W 5
`define ACR_CHAN_MSB_POS 13
`define ACR_RESULT_W 12
`define ACR_LED_LO 4
`define ACR_LED_HI 11
`define ACR_FIFO_DEPTH 8
`define ACR_FIRST_CHAN 3'h0

`endif

// >>> core/acr_pkg.sv
package acr_pkg;
	// A finished conversion tagged with its true channel
	typedef struct packed {
		logic [2:0] chan;
		logic [11:0] value;
	} acr_result_type;

	// Serial link pins toward the converter
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} acr_link_type;

	typedef enum logic [1:0] {ACR_IDLE, ACR_LOW, ACR_HIGH, ACR_GAP} acr_state_type;
endpackage

// >>> core/acr_fifo.sv
`timescale 1ns/10ps
`include "acr_consts.svh"

module acr_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule // acr_fifo

// >>> core/acr_reader.sv
// How it works
// - Switch values 0000 to 0111 pick converter channels zero to seven.
// - LEDs show result bits eleven down to four, bit eleven on top.
// - Chosen channel shifts out on the converter input line each frame.
// - Each received result belongs to the previous frame's channel.
// - First result after reset is tagged as channel zero.
// - Results are plain unsigned binary, no sign or offset change.
// - Serial clock runs at 2 MHz, made from the system clock.
// - Operating clock comes from a 50 MHz reference via a synthesizer.
// - Four-wire link: select, serial clock, data out, data in.
`timescale 1ns/10ps
`include "acr_consts.svh"

module acr_reader
	import acr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] channel_select_switches,
	output logic conv_cs_n,
	output logic conv_sclk,
	output logic conv_din,
	input wire logic conv_dout,
	output logic [7:0] led,
	output logic [2:0] led_chan,
	output logic result_valid,
	output acr_result_type result_data,
	input wire logic result_ready
);
	// the synthesizer sits outside; clk is its 100 MHz output
	acr_state_type state;
	logic [`ACR_DIV_W-1:0] div;
	logic [`ACR_BIT_W-1:0] bit_cnt;
	logic [`ACR_FRAME_BITS-1:0] shift_out;
	logic [`ACR_FRAME_BITS-1:0] shift_in;
	logic [2:0] chan_now;
	logic [2:0] chan_prev;
	logic half_tick;
	logic fifo_in_ready;
	logic fifo_in_valid;
	acr_result_type fifo_in;
	acr_result_type fifo_out;
	logic fifo_out_valid;
	logic led_pop;

	assign half_tick = div == `ACR_DIV_W'(`ACR_SCLK_HALF - 1);

	// Serial clock divider, 2 MHz from the system clock
	always_ff @(posedge clk) begin
		if (!rst_n || half_tick) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// Frame sequencer; waits in the gap while the FIFO is full
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ACR_IDLE;
			bit_cnt <= '0;
		end else if (half_tick) begin
			unique case (state)
				ACR_IDLE: begin
					state <= ACR_LOW;
					bit_cnt <= '0;
				end
				ACR_LOW: begin
					state <= ACR_HIGH;
				end
				ACR_HIGH: begin
					if (bit_cnt == `ACR_BIT_W'(`ACR_FRAME_BITS - 1)) begin
						state <= ACR_GAP;
					end else begin
						state <= ACR_LOW;
						bit_cnt <= bit_cnt + 1'b1;
					end
				end
				ACR_GAP: begin
					if (fifo_in_ready) begin
						state <= ACR_IDLE;
					end
				end
			endcase
		end
	end

	// Shifting: drive on falling edge, sample on rising edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_out <= '0;
			shift_in <= '0;
			chan_now <= `ACR_FIRST_CHAN;
		end else if (half_tick) begin
			if (state == ACR_IDLE) begin
				// Upper switch bit ignored; only eight channels exist
				chan_now <= channel_select_switches[2:0];
				shift_out <= '0;
				shift_out[`ACR_CHAN_MSB_POS -: 3] <= channel_select_switches[2:0];
			end else if (state == ACR_HIGH) begin
				shift_out <= {shift_out[`ACR_FRAME_BITS-2:0], 1'b0};
			end else if (state == ACR_LOW) begin
				shift_in <= {shift_in[`ACR_FRAME_BITS-2:0], conv_dout};
			end
		end
	end

	// Link pins, all registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv_cs_n <= 1'b1;
			conv_sclk <= 1'b1;
			conv_din <= 1'b0;
		end else begin
			conv_cs_n <= !(state == ACR_LOW || state == ACR_HIGH);
			conv_sclk <= state != ACR_LOW;
			conv_din <= shift_out[`ACR_FRAME_BITS-1];
		end
	end

	// Previous channel tag; reset value covers the power-up result
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chan_prev <= `ACR_FIRST_CHAN;
		end else if (half_tick && state == ACR_GAP && fifo_in_ready) begin
			chan_prev <= chan_now;
		end
	end

	assign fifo_in_valid = half_tick && state == ACR_GAP;
	assign fifo_in.chan = chan_prev;
	assign fifo_in.value = shift_in[`ACR_RESULT_W-1:0];

	acr_fifo #(
		.WIDTH($bits(acr_result_type)),
		.DEPTH(`ACR_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(fifo_in),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(led_pop)
	);

	// Downstream consumer holds the head until it takes it
	assign led_pop = fifo_out_valid && (result_ready || !result_valid);

	// Output stage: LEDs and the result stream, registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			led <= '0;
			led_chan <= '0;
			result_valid <= 1'b0;
			result_data <= '0;
		end else begin
			if (led_pop) begin
				led <= fifo_out.value[`ACR_LED_HI:`ACR_LED_LO];
				led_chan <= fifo_out.chan;
				result_data <= fifo_out;
				result_valid <= 1'b1;
			end else if (result_ready) begin
				result_valid <= 1'b0;
			end
		end
	end
endmodule // acr_reader

// >>> bench/acr_reader_chk.sv
`timescale 1ns/10ps
module acr_reader_chk import acr_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic conv_cs_n,
	input wire logic conv_sclk,
	input wire logic conv_din,
	input wire logic [7:0] led,
	input wire logic result_valid,
	input wire acr_result_type result_data,
	input wire logic result_ready
);
	logic [4:0] rises;
	logic sclk_q;
	// Serial clock rises seen in this frame
	always_ff @(posedge clk) begin
		sclk_q <= conv_sclk;
		rises <= conv_cs_n ? 5'h0 : rises + 5'(conv_sclk & ~sclk_q);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_idle_high: assert property (conv_cs_n |-> conv_sclk) else $error("idle");
	a_start_low: assert property ($fell(conv_cs_n) |-> !conv_sclk) else $error("start");
	a_low_phase: assert property ($fell(conv_sclk) |-> ##25 $rose(conv_sclk))
		else $error("phase");
	a_sixteen_rises: assert property ($rose(conv_cs_n) |-> rises == 5'h10)
		else $error("count");
	a_din_steady: assert property (!conv_cs_n && conv_sclk && $past(conv_sclk)
		|-> $stable(conv_din)) else $error("din");
	a_hold_result: assert property (result_valid && !result_ready
		|=> result_valid && $stable(result_data)) else $error("hold");
	// Back-to-back pops while draining move both every cycle, so compare them as they stand
	a_led_update: assert property (result_valid |-> led == result_data.value[11:4])
		else $error("led");
	a_quiet_reset: assert property ($rose(rst_n) |-> conv_cs_n[*8]) else $error("reset");
	c_frame: cover property ($rose(conv_cs_n));
	c_stall: cover property (result_valid && !result_ready);
	c_pop: cover property (result_valid && result_ready);
endmodule // acr_reader_chk
bind acr_reader acr_reader_chk u_chk (.*);

// >>> bench/acr_conv_model.sv
`timescale 1ns/10ps
module acr_conv_model (
	input wire logic conv_cs_n,
	input wire logic conv_sclk,
	input wire logic conv_din,
	output logic conv_dout
);
	logic [2:0] chan = 3'h0;
	logic [15:0] tx, rx;
	int n = 0;
	// Frame start: previous request's result, zeros first
	always @(negedge conv_cs_n) begin
		tx = {4'h0, chan, ~chan, chan, ~chan};
		n = 0;
		conv_dout = 1'b0;
	end
	// Sample on the rise, shift out on the fall
	always @(posedge conv_sclk) if (!conv_cs_n) begin
		rx = {rx[14:0], conv_din};
		n++;
	end
	always @(negedge conv_sclk) if (!conv_cs_n && n > 0) conv_dout = tx[15 - n];
	// Released line flips, it has no pull
	always @(posedge conv_cs_n) begin
		if (n == 16) chan = rx[13:11];
		conv_dout = ~conv_dout;
	end
endmodule // acr_conv_model

// >>> bench/acr_reader_tb.sv
`timescale 1ns/10ps
module acr_reader_tb import acr_pkg::*;;
	logic clk = 0, rst_n = 0, result_ready = 1, conv_dout, result_valid;
	logic conv_cs_n, conv_sclk, conv_din;
	logic [3:0] channel_select_switches = 4'h5;
	logic [7:0] led;
	logic [2:0] led_chan;
	acr_result_type result_data, r;
	int errors = 0, checks_done = 0;
	acr_reader u_dut (.*);
	acr_conv_model u_conv (.*);
	initial forever #5 clk = ~clk;
	task chk(input string s, input logic [14:0] e, g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task summarize;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (70000) @(posedge clk);
		errors++;
		summarize;
	end
	task get;
		@(posedge clk);
		while (result_valid !== 1'b1) @(posedge clk);
		r = result_data;
	endtask
	task take(input logic [2:0] c);
		get;
		chk("res", {c, c, ~c, c, ~c}, r);
		repeat (3) @(posedge clk);
		chk("led", {4'h0, led_chan, led}, {4'h0, c, c, ~c, c[2:1]});
	endtask
	// Spare frames flush the old channel
	task t_sweep;
		take(3'h0);
		take(3'h5);
		for (int c = 0; c < 8; c++) begin
			#1 channel_select_switches = 4'(c);
			repeat (2) get;
			take(3'(c));
		end
		$display("t_sweep done");
	endtask
	task t_stall;
		int busy;
		busy = 0;
		#1 result_ready = 0;
		repeat (10000) @(posedge clk);
		repeat (1000) @(posedge clk) busy += int'(conv_cs_n !== 1'b1);
		chk("stall", 15'h0, 15'(busy));
		#1 result_ready = 1;
		repeat (8) begin
			get;
			chk("drain", 15'h7e38, r);
		end
		$display("t_stall done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1 rst_n = 1;
		t_sweep;
		t_stall;
		summarize;
	end
endmodule // acr_reader_tb
